// >>> rtl/lp_entry_consts.svh
`ifndef LP_ENTRY_CONSTS_SVH
`define LP_ENTRY_CONSTS_SVH

`define LP_CLK_MHZ 25
`define LP_PM_LC_US 3
`define LP_PM_ENTRY_US 6
`define LP_UX_EXIT_US 6000
`define LP_PM_LC_CYC (`LP_PM_LC_US * `LP_CLK_MHZ)
`define LP_PM_ENTRY_CYC (`LP_PM_ENTRY_US * `LP_CLK_MHZ)
`define LP_UX_EXIT_CYC (`LP_UX_EXIT_US * `LP_CLK_MHZ)
`define LP_TMR_W 18
`define LP_U3_LAST 2'h2

`define LP_ADDR_CTRL 8'h00
`define LP_ADDR_STATUS 8'h04
`define LP_ADDR_U2TO 8'h08
`define LP_CTRL_GO 0
`define LP_CTRL_TGT 1
`define LP_CTRL_DS 3
`define LP_CTRL_FORCE 4
`define LP_CTRL_REJ 5
`define LP_CTRL_U2EN 6
`define LP_CTRL_EXIT 7
`define LP_CTRL_HLOK 8
`define LP_U2TO_RST 16'h0000
`define LP_RESP_OKAY 2'h0
`define LP_RESP_SLVERR 2'h2
`endif

// >>> rtl/lpe_pkg.sv
package lpe_pkg;
  typedef enum logic [10:0] {
    S_U0 = 11'h001,
    S_TX_GO = 11'h002,
    S_WAIT_RSP = 11'h004,
    S_TX_ACK = 11'h008,
    S_TX_ACC = 11'h010,
    S_TX_REJ = 11'h020,
    S_WAIT_ACK = 11'h040,
    S_LOW = 11'h080,
    S_EXIT = 11'h100,
    S_RECOV = 11'h200,
    S_INACT = 11'h400
  } state_type;

  typedef enum logic [2:0] {
    L_U0 = 3'h0, L_U1 = 3'h1, L_U2 = 3'h2, L_U3 = 3'h3, L_RECOV = 3'h4, L_INACT = 3'h5
  } lstate_type;

  typedef enum logic [2:0] {
    C_NONE = 3'h0, C_GO_U1 = 3'h1, C_GO_U2 = 3'h2, C_GO_U3 = 3'h3,
    C_ACCEPT = 3'h4, C_REJECT = 3'h5, C_PMACK = 3'h6
  } cmd_type;

  typedef struct packed {
    logic acks_sent;
    logic acks_rcvd;
    logic tx_pending;
    logic adv_done;
    logic ts1;
    logic lfps_exit;
    logic in_u0;
  } link_stat_type;

  typedef struct packed {
    logic valid;
    cmd_type code;
  } lcmd_type;
endpackage

// >>> rtl/lp_entry_ctrl.sv
`timescale 1ns/1ps
`include "lp_entry_consts.svh"
module lp_entry_ctrl #(
  parameter logic [17:0] P_PM_LC_CYC = 18'(`LP_PM_LC_CYC),
  parameter logic [17:0] P_PM_ENTRY_CYC = 18'(`LP_PM_ENTRY_CYC),
  parameter logic [17:0] P_UX_EXIT_CYC = 18'(`LP_UX_EXIT_CYC)
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_s_awvalid,
  output logic o_s_awready,
  input wire logic [7:0] i_s_awaddr,
  input wire logic i_s_wvalid,
  output logic o_s_wready,
  input wire logic [31:0] i_s_wdata,
  input wire logic [3:0] i_s_wstrb,
  output logic o_s_bvalid,
  input wire logic i_s_bready,
  output logic [1:0] o_s_bresp,
  input wire logic i_s_arvalid,
  output logic o_s_arready,
  input wire logic [7:0] i_s_araddr,
  output logic o_s_rvalid,
  input wire logic i_s_rready,
  output logic [31:0] o_s_rdata,
  output logic [1:0] o_s_rresp,
  input wire lpe_pkg::link_stat_type i_link,
  input wire lpe_pkg::lcmd_type i_rx_cmd,
  input wire logic i_tx_done,
  output lpe_pkg::lcmd_type o_tx_cmd,
  output logic o_tx_block,
  output logic o_rx_discard,
  output logic o_abort_unacked,
  output logic o_lfps_exit_start,
  output logic o_lfps_exit_resp,
  output lpe_pkg::lstate_type o_link_state
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic tmr_exp(input logic run, input logic [17:0] cnt, input logic [17:0] tc);
    return run && (cnt == tc - 18'h1);
  endfunction

  function automatic logic [18:0] tmr_step(input logic run, input logic [17:0] cnt, input logic start,
                                           input logic stop, input logic [17:0] tc);
    if (start) begin
      return {1'b1, 18'h0};
    end
    if (stop) begin
      return 19'h0;
    end
    if (run && (cnt != tc - 18'h1)) begin
      return {1'b1, 18'(cnt + 18'h1)};
    end
    return {run, cnt};
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return (a == `LP_ADDR_CTRL) || (a == `LP_ADDR_STATUS) || (a == `LP_ADDR_U2TO);
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  lpe_pkg::state_type state_r, state_nxt;
  lpe_pkg::lstate_type lstate_r, lstate_nxt, req_r, req_nxt;
  lpe_pkg::cmd_type send_nxt;
  logic [1:0] tgt_r;
  logic ds_r, force_r, rej_r, u2en_r, hlok_r, go_pend_r, exit_pend_r;
  logic [15:0] u2to_r, u2_cnt_r;
  logic lc_run_r, ent_run_r, ux_run_r;
  logic [17:0] lc_cnt_r, ent_cnt_r, ux_cnt_r;
  logic [1:0] u3_cnt_r;
  logic retry_u3_r, exit_seen_r;
  logic lc_start, lc_stop, ent_start, ent_stop, ux_start, ux_stop;
  logic abort, resp, exit_start, go_clr, exit_clr, u3_inc, u3_ok, retry_set;
  logic wr_hs, wr_take, rd_take;
  logic [31:0] ctrl_rd, status_rd;
  logic link_ok, go_ok, retry_ok, rxv, lc_exp, ent_exp, ux_exp, u2_exp;
  lpe_pkg::lstate_type tgt_state;

  assign link_ok = i_link.acks_sent && i_link.acks_rcvd && !i_link.tx_pending && i_link.adv_done;
  assign tgt_state = lpe_pkg::lstate_type'({1'b0, tgt_r});
  assign go_ok = go_pend_r && hlok_r && link_ok && (tgt_r != 2'h0) &&
                 (tgt_state != lpe_pkg::L_U3 || ds_r);
  assign retry_ok = retry_u3_r && link_ok;
  assign rxv = i_rx_cmd.valid;
  assign lc_exp = tmr_exp(lc_run_r, lc_cnt_r, P_PM_LC_CYC);
  assign ent_exp = tmr_exp(ent_run_r, ent_cnt_r, P_PM_ENTRY_CYC);
  assign ux_exp = tmr_exp(ux_run_r, ux_cnt_r, P_UX_EXIT_CYC);
  assign u2_exp = u2en_r && (u2to_r != 16'h0) && (u2_cnt_r == u2to_r);

  // ----------------------------------------
  // Register slave
  // ----------------------------------------
  assign wr_hs = i_s_awvalid && i_s_wvalid && !o_s_awready && !o_s_bvalid;
  assign wr_take = o_s_awready && i_s_awvalid && i_s_wvalid;
  assign rd_take = o_s_arready && i_s_arvalid;
  assign ctrl_rd = {23'h0, hlok_r, exit_pend_r, u2en_r, rej_r, force_r, ds_r, tgt_r, go_pend_r};
  assign status_rd = {13'h0, state_r, ux_run_r, ent_run_r, lc_run_r, u3_cnt_r, lstate_r};

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_s_awready <= 1'b0;
      o_s_wready <= 1'b0;
      o_s_bvalid <= 1'b0;
      o_s_bresp <= `LP_RESP_OKAY;
    end else if (i_ce) begin
      o_s_awready <= wr_hs;
      o_s_wready <= wr_hs;
      if (wr_take) begin
        o_s_bvalid <= 1'b1;
        o_s_bresp <= is_mapped(i_s_awaddr) ? `LP_RESP_OKAY : `LP_RESP_SLVERR;
      end else if (o_s_bvalid && i_s_bready) begin
        o_s_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_s_arready <= 1'b0;
      o_s_rvalid <= 1'b0;
      o_s_rdata <= 32'h0;
      o_s_rresp <= `LP_RESP_OKAY;
    end else if (i_ce) begin
      o_s_arready <= i_s_arvalid && !o_s_arready && !o_s_rvalid;
      if (rd_take) begin
        o_s_rvalid <= 1'b1;
        o_s_rresp <= is_mapped(i_s_araddr) ? `LP_RESP_OKAY : `LP_RESP_SLVERR;
        case (i_s_araddr)
          `LP_ADDR_CTRL: o_s_rdata <= ctrl_rd;
          `LP_ADDR_STATUS: o_s_rdata <= status_rd;
          `LP_ADDR_U2TO: o_s_rdata <= {16'h0, u2to_r};
          default: o_s_rdata <= 32'h0;
        endcase
      end else if (o_s_rvalid && i_s_rready) begin
        o_s_rvalid <= 1'b0;
      end
    end
  end

  // Control fields; a software set of go or exit wins over the hardware clear
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      tgt_r <= 2'h0;
      ds_r <= 1'b0;
      force_r <= 1'b0;
      rej_r <= 1'b0;
      u2en_r <= 1'b0;
      hlok_r <= 1'b0;
      go_pend_r <= 1'b0;
      exit_pend_r <= 1'b0;
      u2to_r <= `LP_U2TO_RST;
    end else if (i_ce) begin
      if (go_clr) begin
        go_pend_r <= 1'b0;
      end
      if (exit_clr) begin
        exit_pend_r <= 1'b0;
      end
      if (wr_take && i_s_awaddr == `LP_ADDR_CTRL && i_s_wstrb[0]) begin
        tgt_r <= i_s_wdata[`LP_CTRL_TGT +: 2];
        ds_r <= i_s_wdata[`LP_CTRL_DS];
        force_r <= i_s_wdata[`LP_CTRL_FORCE];
        rej_r <= i_s_wdata[`LP_CTRL_REJ];
        u2en_r <= i_s_wdata[`LP_CTRL_U2EN];
        if (i_s_wdata[`LP_CTRL_GO]) begin
          go_pend_r <= 1'b1;
        end
        if (i_s_wdata[`LP_CTRL_EXIT]) begin
          exit_pend_r <= 1'b1;
        end
      end
      if (wr_take && i_s_awaddr == `LP_ADDR_CTRL && i_s_wstrb[1]) begin
        hlok_r <= i_s_wdata[`LP_CTRL_HLOK];
      end
      if (wr_take && i_s_awaddr == `LP_ADDR_U2TO) begin
        if (i_s_wstrb[0]) begin
          u2to_r[7:0] <= i_s_wdata[7:0];
        end
        if (i_s_wstrb[1]) begin
          u2to_r[15:8] <= i_s_wdata[15:8];
        end
      end
    end
  end

  // ----------------------------------------
  // Entry and exit sequencing
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    lstate_nxt = lstate_r;
    req_nxt = req_r;
    send_nxt = lpe_pkg::C_NONE;
    {lc_start, lc_stop, ent_start, ent_stop, ux_start, ux_stop} = 6'h00;
    {abort, resp, exit_start, go_clr, exit_clr, u3_inc, u3_ok, retry_set} = 8'h00;
    case (state_r)
      lpe_pkg::S_U0: begin
        lstate_nxt = lpe_pkg::L_U0;
        if (rxv && (i_rx_cmd.code == lpe_pkg::C_GO_U1 || i_rx_cmd.code == lpe_pkg::C_GO_U2)) begin
          req_nxt = (i_rx_cmd.code == lpe_pkg::C_GO_U1) ? lpe_pkg::L_U1 : lpe_pkg::L_U2;
          if (force_r || (link_ok && !rej_r)) begin
            state_nxt = lpe_pkg::S_TX_ACC;
            send_nxt = lpe_pkg::C_ACCEPT;
          end else begin
            state_nxt = lpe_pkg::S_TX_REJ;
            send_nxt = lpe_pkg::C_REJECT;
          end
        end else if (rxv && i_rx_cmd.code == lpe_pkg::C_GO_U3 && !ds_r) begin
          req_nxt = lpe_pkg::L_U3;
          state_nxt = lpe_pkg::S_TX_ACC;
          send_nxt = lpe_pkg::C_ACCEPT;
          abort = 1'b1;
        end else if (retry_ok) begin
          req_nxt = lpe_pkg::L_U3;
          state_nxt = lpe_pkg::S_TX_GO;
          send_nxt = lpe_pkg::C_GO_U3;
        end else if (go_ok) begin
          req_nxt = tgt_state;
          state_nxt = lpe_pkg::S_TX_GO;
          send_nxt = lpe_pkg::cmd_type'({1'b0, tgt_r});
          go_clr = 1'b1;
        end
      end
      lpe_pkg::S_TX_GO: begin
        if (i_tx_done) begin
          lc_start = 1'b1;
          state_nxt = lpe_pkg::S_WAIT_RSP;
        end
      end
      lpe_pkg::S_WAIT_RSP: begin
        if (rxv && (i_rx_cmd.code == lpe_pkg::C_ACCEPT || i_rx_cmd.code == lpe_pkg::C_REJECT)) begin
          lc_stop = 1'b1;
          if (i_rx_cmd.code == lpe_pkg::C_ACCEPT) begin
            state_nxt = lpe_pkg::S_TX_ACK;
            send_nxt = lpe_pkg::C_PMACK;
          end else begin
            state_nxt = lpe_pkg::S_U0;
          end
        end else if (i_link.ts1) begin
          lc_stop = 1'b1;
          state_nxt = lpe_pkg::S_RECOV;
        end else if (lc_exp) begin
          lc_stop = 1'b1;
          if (req_r == lpe_pkg::L_U3) begin
            u3_inc = 1'b1;
            if (u3_cnt_r == `LP_U3_LAST) begin
              state_nxt = lpe_pkg::S_INACT;
            end else begin
              retry_set = 1'b1;
              state_nxt = lpe_pkg::S_RECOV;
            end
          end else begin
            state_nxt = lpe_pkg::S_RECOV;
          end
        end
      end
      lpe_pkg::S_TX_ACK: begin
        if (i_tx_done) begin
          state_nxt = lpe_pkg::S_LOW;
          lstate_nxt = req_r;
          u3_ok = (req_r == lpe_pkg::L_U3);
        end
      end
      lpe_pkg::S_TX_ACC: begin
        if (i_tx_done) begin
          ent_start = 1'b1;
          state_nxt = lpe_pkg::S_WAIT_ACK;
        end
      end
      lpe_pkg::S_TX_REJ: begin
        if (i_tx_done) begin
          state_nxt = lpe_pkg::S_U0;
        end
      end
      lpe_pkg::S_WAIT_ACK: begin
        if (rxv && i_rx_cmd.code == lpe_pkg::C_PMACK) begin
          ent_stop = 1'b1;
          state_nxt = lpe_pkg::S_LOW;
          lstate_nxt = req_r;
        end else if (i_link.ts1) begin
          ent_stop = 1'b1;
          state_nxt = lpe_pkg::S_RECOV;
        end else if (ent_exp) begin
          ent_stop = 1'b1;
          state_nxt = lpe_pkg::S_LOW;
          lstate_nxt = req_r;
        end
      end
      lpe_pkg::S_LOW: begin
        if (i_link.lfps_exit || exit_seen_r) begin
          resp = 1'b1;
          exit_clr = 1'b1;
          state_nxt = lpe_pkg::S_RECOV;
        end else if (exit_pend_r) begin
          exit_start = 1'b1;
          exit_clr = 1'b1;
          ux_start = (lstate_r != lpe_pkg::L_U3);
          state_nxt = lpe_pkg::S_EXIT;
        end else if (lstate_r == lpe_pkg::L_U1 && u2_exp) begin
          lstate_nxt = lpe_pkg::L_U2;
        end
      end
      lpe_pkg::S_EXIT: begin
        if (i_link.in_u0) begin
          ux_stop = 1'b1;
          state_nxt = lpe_pkg::S_U0;
        end else if (ux_exp) begin
          ux_stop = 1'b1;
          state_nxt = lpe_pkg::S_INACT;
        end
      end
      lpe_pkg::S_RECOV: begin
        lstate_nxt = lpe_pkg::L_RECOV;
        if (i_link.in_u0) begin
          state_nxt = lpe_pkg::S_U0;
        end
      end
      lpe_pkg::S_INACT: begin
        lstate_nxt = lpe_pkg::L_INACT;
      end
      default: begin
        state_nxt = lpe_pkg::S_U0;
      end
    endcase
    if (state_nxt == lpe_pkg::S_RECOV) begin
      lstate_nxt = lpe_pkg::L_RECOV;
    end else if (state_nxt == lpe_pkg::S_INACT) begin
      lstate_nxt = lpe_pkg::L_INACT;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state_r <= lpe_pkg::S_U0;
      lstate_r <= lpe_pkg::L_U0;
      req_r <= lpe_pkg::L_U0;
    end else if (i_ce) begin
      state_r <= state_nxt;
      lstate_r <= lstate_nxt;
      req_r <= req_nxt;
    end
  end

  // U3 attempt count and retry flag
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      u3_cnt_r <= 2'h0;
      retry_u3_r <= 1'b0;
    end else if (i_ce) begin
      if (u3_ok) begin
        u3_cnt_r <= 2'h0;
      end else if (u3_inc) begin
        u3_cnt_r <= 2'(u3_cnt_r + 2'h1);
      end
      if (retry_set) begin
        retry_u3_r <= 1'b1;
      end else if (state_r == lpe_pkg::S_U0 && state_nxt == lpe_pkg::S_TX_GO && retry_ok) begin
        retry_u3_r <= 1'b0;
      end
    end
  end

  // LFPS exit seen while waiting for the acknowledge is held until S_LOW is left after entry
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      exit_seen_r <= 1'b0;
    end else if (i_ce) begin
      if (state_r == lpe_pkg::S_WAIT_ACK && i_link.lfps_exit) begin
        exit_seen_r <= 1'b1;
      end else if (state_r == lpe_pkg::S_LOW && state_nxt != lpe_pkg::S_LOW) begin
        exit_seen_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Timers
  // ----------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      {lc_run_r, lc_cnt_r} <= 19'h0;
      {ent_run_r, ent_cnt_r} <= 19'h0;
      {ux_run_r, ux_cnt_r} <= 19'h0;
    end else if (i_ce) begin
      {lc_run_r, lc_cnt_r} <= tmr_step(lc_run_r, lc_cnt_r, lc_start, lc_stop, P_PM_LC_CYC);
      {ent_run_r, ent_cnt_r} <= tmr_step(ent_run_r, ent_cnt_r, ent_start, ent_stop, P_PM_ENTRY_CYC);
      {ux_run_r, ux_cnt_r} <= tmr_step(ux_run_r, ux_cnt_r, ux_start, ux_stop, P_UX_EXIT_CYC);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      u2_cnt_r <= 16'h0;
    end else if (i_ce) begin
      if (lstate_r != lpe_pkg::L_U1 || state_r != lpe_pkg::S_LOW || i_link.lfps_exit) begin
        u2_cnt_r <= 16'h0;
      end else if (!u2_exp) begin
        u2_cnt_r <= 16'(u2_cnt_r + 16'h1);
      end
    end
  end

  // ----------------------------------------
  // Link side outputs
  // ----------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_tx_cmd <= '{valid: 1'b0, code: lpe_pkg::C_NONE};
      o_tx_block <= 1'b0;
      o_rx_discard <= 1'b0;
      o_abort_unacked <= 1'b0;
      o_lfps_exit_start <= 1'b0;
      o_lfps_exit_resp <= 1'b0;
      o_link_state <= lpe_pkg::L_U0;
    end else if (i_ce) begin
      if (send_nxt != lpe_pkg::C_NONE) begin
        o_tx_cmd <= '{valid: 1'b1, code: send_nxt};
      end else if (i_tx_done) begin
        o_tx_cmd <= '{valid: 1'b0, code: lpe_pkg::C_NONE};
      end
      o_tx_block <= (state_nxt != lpe_pkg::S_U0) && (state_nxt != lpe_pkg::S_TX_REJ);
      o_rx_discard <= (req_nxt == lpe_pkg::L_U3) && (state_nxt == lpe_pkg::S_TX_GO ||
                      state_nxt == lpe_pkg::S_WAIT_RSP || state_nxt == lpe_pkg::S_TX_ACK);
      o_abort_unacked <= abort;
      o_lfps_exit_start <= exit_start;
      o_lfps_exit_resp <= resp;
      o_link_state <= lstate_nxt;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  lc_start_a : assert property (
    state_r == lpe_pkg::S_TX_GO && i_tx_done && i_ce |=> lc_run_r && lc_cnt_r == 18'h0 && o_tx_block)
    else $error("response timer not started after request");
  lc_stop_a : assert property (
    state_r == lpe_pkg::S_WAIT_RSP && rxv && i_ce &&
    (i_rx_cmd.code == lpe_pkg::C_ACCEPT || i_rx_cmd.code == lpe_pkg::C_REJECT) |=> !lc_run_r)
    else $error("response timer not stopped on answer");
  ent_start_a : assert property (
    state_r == lpe_pkg::S_TX_ACC && i_tx_done && i_ce |=> ent_run_r && state_r == lpe_pkg::S_WAIT_ACK)
    else $error("entry timer not started after accept");
  ent_stop_a : assert property (
    state_r == lpe_pkg::S_WAIT_ACK && i_ce && (i_link.ts1 || (rxv && i_rx_cmd.code == lpe_pkg::C_PMACK))
    |=> !ent_run_r)
    else $error("entry timer not stopped");
  go_gate_a : assert property (
    $rose(o_tx_cmd.valid) && o_tx_cmd.code inside {lpe_pkg::C_GO_U1, lpe_pkg::C_GO_U2}
    |-> $past(link_ok) && $past(hlok_r))
    else $error("entry request without preconditions");
  ack_send_a : assert property (
    state_r == lpe_pkg::S_WAIT_RSP && rxv && i_rx_cmd.code == lpe_pkg::C_ACCEPT && i_ce
    |=> o_tx_cmd.valid && o_tx_cmd.code == lpe_pkg::C_PMACK)
    else $error("no acknowledge after accept");
  lc_recov_a : assert property (
    state_r == lpe_pkg::S_WAIT_RSP && lc_exp && !rxv && !i_link.ts1 && req_r != lpe_pkg::L_U3 && i_ce
    |=> o_link_state == lpe_pkg::L_RECOV)
    else $error("no recovery after response timeout");
  u3_inact_a : assert property (
    state_r == lpe_pkg::S_WAIT_RSP && lc_exp && !rxv && !i_link.ts1 && req_r == lpe_pkg::L_U3 &&
    u3_cnt_r == 2'h2 && i_ce |=> o_link_state == lpe_pkg::L_INACT)
    else $error("no inactive state after third U3 failure");
  ent_expire_a : assert property (
    state_r == lpe_pkg::S_WAIT_ACK && ent_exp && !rxv && !i_link.ts1 && i_ce
    |=> state_r == lpe_pkg::S_LOW && o_link_state == req_r)
    else $error("low power state not entered at entry timeout");
  blk_acc_a : assert property (
    state_r inside {lpe_pkg::S_WAIT_ACK, lpe_pkg::S_TX_ACK, lpe_pkg::S_LOW} |-> o_tx_block)
    else $error("packets not blocked after accept or acknowledge");
endmodule

// >>> tb/link_partner.sv
`timescale 1ns/1ps
module link_partner (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [1:0] i_mode,
  input wire lpe_pkg::lcmd_type i_tx_cmd,
  input wire lpe_pkg::lcmd_type i_req,
  output logic o_tx_done,
  output lpe_pkg::lcmd_type o_rx_cmd
);
  logic [2:0] cnt_r;
  logic ans_r, acc_r;
  // ----------------------------------------
  // Command sink and single answer
  // ----------------------------------------
  always_ff @(posedge i_mclk) begin
    o_tx_done <= 1'b0;
    o_rx_cmd <= '0;
    if (i_reset) begin
      cnt_r <= 3'h0;
      ans_r <= 1'b0;
      acc_r <= 1'b0;
    end else if (i_tx_cmd.valid && !o_tx_done) begin
      cnt_r <= cnt_r + 3'h1;
      if (cnt_r == 3'h3) begin
        o_tx_done <= 1'b1;
        cnt_r <= 3'h0;
        ans_r <= i_tx_cmd.code inside {lpe_pkg::C_GO_U1, lpe_pkg::C_GO_U2, lpe_pkg::C_GO_U3, lpe_pkg::C_ACCEPT};
        acc_r <= i_tx_cmd.code == lpe_pkg::C_ACCEPT;
      end
    end else if (ans_r) begin
      ans_r <= 1'b0;
      if (i_mode != 2'h2) begin
        o_rx_cmd <= {1'b1, acc_r ? lpe_pkg::C_PMACK : (i_mode == 2'h0) ? lpe_pkg::C_ACCEPT : lpe_pkg::C_REJECT};
      end
    end else if (i_req.valid) begin
      o_rx_cmd <= i_req;
    end
  end
endmodule

// >>> tb/link_low_power_entry_control_test.sv
`timescale 1ns/1ps
module link_low_power_entry_control_test;
  typedef struct {logic [31:0] ctrl; logic [6:0] lk; logic [1:0] md; lpe_pkg::lstate_type ex;
    lpe_pkg::cmd_type rq;} row_type;
  logic i_mclk = 0, i_reset = 1, aw = 0, w = 0, b = 0, ar = 0, r = 0;
  logic [7:0] aa = 0, ra = 0;
  logic [31:0] wd = 0, rd, rdat;
  logic [1:0] mode = 0, rsp, br, rr;
  lpe_pkg::link_stat_type lnk = '0;
  lpe_pkg::lcmd_type txc, rxc;
  logic txd, awr, wr, bv, arr, rv, blk, dis, abt, xs, xr, ce = 1'b1;
  logic [2:0] seen;
  lpe_pkg::lcmd_type rq = '0;
  lpe_pkg::lstate_type st;
  int num_errors = 0, n_tests = 0, wdg;
  row_type rows[13];
  lp_entry_ctrl #(.P_PM_LC_CYC(18'h14), .P_PM_ENTRY_CYC(18'h1e), .P_UX_EXIT_CYC(18'hc8)) DUT (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_ce(ce), .i_s_awvalid(aw), .o_s_awready(awr), .i_s_awaddr(aa),
    .i_s_wvalid(w), .o_s_wready(wr), .i_s_wdata(wd), .i_s_wstrb(4'hf), .o_s_bvalid(bv), .i_s_bready(b),
    .o_s_bresp(br), .i_s_arvalid(ar), .o_s_arready(arr), .i_s_araddr(ra), .o_s_rvalid(rv), .i_s_rready(r),
    .o_s_rdata(rdat), .o_s_rresp(rr), .i_link(lnk), .i_rx_cmd(rxc), .i_tx_done(txd), .o_tx_cmd(txc),
    .o_tx_block(blk), .o_rx_discard(dis), .o_abort_unacked(abt), .o_lfps_exit_start(xs),
    .o_lfps_exit_resp(xr), .o_link_state(st));
  link_partner partner (.i_mclk(i_mclk), .i_reset(i_reset), .i_mode(mode), .i_tx_cmd(txc), .i_req(rq),
    .o_tx_done(txd), .o_rx_cmd(rxc));
  initial begin
    forever #20 i_mclk = ~i_mclk;
  end
  // Sticky record of the one-cycle pulses
  always @(posedge i_mclk) begin
    seen <= i_reset ? 3'h0 : (seen | {abt, xs, xr});
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic end_sim();
    if (num_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic tick();
    @(posedge i_mclk);
    wdg++;
    if (wdg > 200) begin
      num_errors++;
      end_sim();
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] o);
    @(posedge i_mclk);
    aw <= 1'b1; w <= 1'b1; aa <= a; wd <= d; wdg = 0;
    do tick(); while (awr !== 1'b1);
    aw <= 1'b0; w <= 1'b0; b <= 1'b1;
    do tick(); while (bv !== 1'b1);
    o = br;
    b <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] o);
    @(posedge i_mclk);
    ar <= 1'b1; ra <= a; wdg = 0;
    do tick(); while (arr !== 1'b1);
    ar <= 1'b0; r <= 1'b1;
    do tick(); while (rv !== 1'b1);
    d = rdat;
    o = rr;
    r <= 1'b0;
  endtask
  task automatic do_reset();
    i_reset <= 1'b1;
    repeat (5) @(posedge i_mclk);
    i_reset <= 1'b0;
    @(posedge i_mclk);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rows = '{'{32'h103, 7'h68, 2'h0, lpe_pkg::L_U1, lpe_pkg::C_NONE},
      '{32'h105, 7'h68, 2'h0, lpe_pkg::L_U2, lpe_pkg::C_NONE},
      '{32'h105, 7'h68, 2'h1, lpe_pkg::L_U0, lpe_pkg::C_NONE},
      '{32'h103, 7'h68, 2'h2, lpe_pkg::L_RECOV, lpe_pkg::C_NONE},
      '{32'h105, 7'h78, 2'h0, lpe_pkg::L_U0, lpe_pkg::C_NONE},
      '{32'h10f, 7'h68, 2'h0, lpe_pkg::L_U3, lpe_pkg::C_NONE},
      '{32'h10f, 7'h69, 2'h2, lpe_pkg::L_INACT, lpe_pkg::C_NONE},
      '{32'h100, 7'h68, 2'h0, lpe_pkg::L_U2, lpe_pkg::C_GO_U2},
      '{32'h100, 7'h68, 2'h2, lpe_pkg::L_U1, lpe_pkg::C_GO_U1},
      '{32'h120, 7'h68, 2'h0, lpe_pkg::L_U0, lpe_pkg::C_GO_U1},
      '{32'h110, 7'h78, 2'h0, lpe_pkg::L_U1, lpe_pkg::C_GO_U1},
      '{32'h100, 7'h6c, 2'h2, lpe_pkg::L_RECOV, lpe_pkg::C_GO_U1},
      '{32'h100, 7'h68, 2'h0, lpe_pkg::L_U3, lpe_pkg::C_GO_U3}};
    do_reset();
    chk("reset state", lpe_pkg::L_U0, st);
    chk("reset tx valid", 1'b0, txc.valid);
    foreach (rows[i]) begin
      do_reset();
      lnk <= rows[i].lk;
      mode <= rows[i].md;
      axi_wr(8'h00, rows[i].ctrl, rsp);
      chk("ctrl bresp", 2'h0, rsp);
      rq <= '{valid: rows[i].rq != lpe_pkg::C_NONE, code: rows[i].rq};
      @(posedge i_mclk);
      rq <= '0;
      repeat (300) @(posedge i_mclk);
      chk("link state", rows[i].ex, st);
      chk("abort", rows[i].rq == lpe_pkg::C_GO_U3, seen[2]);
      axi_rd(8'h04, rd, rsp);
      chk("status state", rows[i].ex, rd[2:0]);
    end
    // U1 to U2 by inactivity, then exit that never reaches U0
    do_reset();
    lnk <= 7'h68;
    mode <= 2'h0;
    axi_wr(8'h08, 32'h20, rsp);
    axi_wr(8'h00, 32'h143, rsp);
    repeat (80) @(posedge i_mclk);
    chk("u2 by inactivity", lpe_pkg::L_U2, st);
    axi_wr(8'h00, 32'h180, rsp);
    repeat (180) @(posedge i_mclk);
    chk("exit start", 1'b1, seen[1]);
    axi_rd(8'h04, rd, rsp);
    chk("exit timer run", 1'b1, rd[7]);
    repeat (30) @(posedge i_mclk);
    chk("exit timeout", lpe_pkg::L_INACT, st);
    // Exit signal during entry wait is answered only after entry
    do_reset();
    lnk <= 7'h68;
    mode <= 2'h2;
    axi_wr(8'h00, 32'h100, rsp);
    rq <= '{valid: 1'b1, code: lpe_pkg::C_GO_U1};
    @(posedge i_mclk);
    rq <= '0;
    repeat (10) @(posedge i_mclk);
    lnk <= 7'h6a;
    repeat (3) @(posedge i_mclk);
    lnk <= 7'h68;
    chk("accept blocks tx", 1'b1, blk);
    chk("no early exit answer", 1'b0, seen[0]);
    repeat (40) @(posedge i_mclk);
    chk("exit answer after entry", 1'b1, seen[0]);
    chk("recovery after exit", lpe_pkg::L_RECOV, st);
    // U3 request discards and blocks; clock enable low freezes the wait
    do_reset();
    lnk <= 7'h68;
    axi_wr(8'h00, 32'h10f, rsp);
    repeat (10) @(posedge i_mclk);
    chk("u3 discard", 1'b1, dis);
    chk("request blocks tx", 1'b1, blk);
    ce <= 1'b0;
    repeat (40) @(posedge i_mclk);
    chk("frozen state", lpe_pkg::L_U0, st);
    ce <= 1'b1;
    repeat (40) @(posedge i_mclk);
    chk("u3 retry recovery", lpe_pkg::L_RECOV, st);
    axi_rd(8'h40, rd, rsp);
    chk("unmapped rresp", 2'h2, rsp);
    axi_wr(8'h40, 32'h1, rsp);
    chk("unmapped bresp", 2'h2, rsp);
    end_sim();
  end
endmodule
